// ==== verilog/tpg_pkg.sv ====
// Constants, register map and stream carrier of the test pattern frame timer
//--------------------------------------------------------------
//--------------------------------------------------------------
package tpg_pkg;

    //--------------------------------------------------------------
    // Register indices (byte address is four times the index)
    //--------------------------------------------------------------
    localparam logic [4:0] IDX_CONTROL = 5'h01;
    localparam logic [4:0] IDX_CONFIG = 5'h02;
    localparam logic [4:0] IDX_LINE_SIZE_UPPER = 5'h04;
    localparam logic [4:0] IDX_LINE_SIZE_LOWER = 5'h05;
    localparam logic [4:0] IDX_BAR_SIZE_UPPER = 5'h06;
    localparam logic [4:0] IDX_BAR_SIZE_LOWER = 5'h07;
    localparam logic [4:0] IDX_ACTIVE_LINES_UPPER = 5'h08;
    localparam logic [4:0] IDX_ACTIVE_LINES_LOWER = 5'h09;
    localparam logic [4:0] IDX_TOTAL_LINES_UPPER = 5'h0A;
    localparam logic [4:0] IDX_TOTAL_LINES_LOWER = 5'h0B;
    localparam logic [4:0] IDX_LINE_PERIOD_UPPER = 5'h0C;
    localparam logic [4:0] IDX_LINE_PERIOD_LOWER = 5'h0D;
    localparam logic [4:0] IDX_BACK_PORCH_LINES = 5'h0E;
    localparam logic [4:0] IDX_FRONT_PORCH_LINES = 5'h0F;
    localparam logic [4:0] IDX_PATTERN_BYTE_ZERO = 5'h10;
    localparam logic [4:0] IDX_PATTERN_BYTE_ONE = 5'h11;
    localparam logic [4:0] IDX_PATTERN_BYTE_TWO = 5'h12;
    localparam logic [4:0] IDX_STATUS = 5'h1F;
    localparam int REG_COUNT = 32;

    //--------------------------------------------------------------
    // Values after reset
    //--------------------------------------------------------------
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_CONFIG = 8'h33;
    localparam logic [7:0] RST_LINE_SIZE_UPPER = 8'h07;
    localparam logic [7:0] RST_LINE_SIZE_LOWER = 8'h80;
    localparam logic [7:0] RST_BAR_SIZE_UPPER = 8'h00;
    localparam logic [7:0] RST_BAR_SIZE_LOWER = 8'hF0;
    localparam logic [7:0] RST_ACTIVE_LINES_UPPER = 8'h01;
    localparam logic [7:0] RST_ACTIVE_LINES_LOWER = 8'hE0;
    localparam logic [7:0] RST_TOTAL_LINES_UPPER = 8'h02;
    localparam logic [7:0] RST_TOTAL_LINES_LOWER = 8'h0D;
    localparam logic [7:0] RST_LINE_PERIOD_UPPER = 8'h0C;
    localparam logic [7:0] RST_LINE_PERIOD_LOWER = 8'h67;
    localparam logic [7:0] RST_BACK_PORCH_LINES = 8'h21;
    localparam logic [7:0] RST_FRONT_PORCH_LINES = 8'h0A;
    localparam logic [7:0] RST_PATTERN_BYTE_ZERO = 8'hAA;
    localparam logic [7:0] RST_PATTERN_BYTE_ONE = 8'h33;
    localparam logic [7:0] RST_PATTERN_BYTE_TWO = 8'hF0;
    localparam logic [7:0] RST_ZERO = 8'h00;

    //--------------------------------------------------------------
    // Field positions and masks
    //--------------------------------------------------------------
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CFG_FIXED_BIT = 7;
    localparam int CFG_BARS_LSB = 4;
    localparam int CFG_BLOCK_LSB = 0;
    localparam logic [7:0] CFG_WRITE_MASK = 8'hBF;
    localparam logic [7:0] CTRL_WRITE_MASK = 8'h01;
    localparam logic [3:0] BLOCK_MIN = 4'h1;
    localparam logic [3:0] BLOCK_MAX = 4'hC;
    localparam logic [7:0] UNPROGRAMMED_BYTE = 8'h00;

    //--------------------------------------------------------------
    // Bus answers
    //--------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    //--------------------------------------------------------------
    // Generated stream carrier
    //--------------------------------------------------------------
    typedef struct packed {
        logic frame_start;
        logic frame_end;
        logic line_start;
        logic valid;
        logic last;
        logic [7:0] data;
    } tpg_stream_type;

endpackage : tpg_pkg

// ==== verilog/tpg_frame_timing.sv ====
// Frame timing and colour byte generator with its AXI4-Lite register file
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ns
module tpg_frame_timing
#(
    parameter int ADDR_W = 8,
    parameter int UNIT_CYCLES = 1
)
(
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic [ADDR_W-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [ADDR_W-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    output tpg_pkg::tpg_stream_type o_stream
);

    //--------------------------------------------------------------
    // Parameter checks
    //--------------------------------------------------------------
    if (ADDR_W < 8) begin : g_bad_addr
        $error("ADDR_W must be at least 8");
    end
    if (UNIT_CYCLES < 1 || UNIT_CYCLES > 65535) begin : g_bad_unit
        $error("UNIT_CYCLES must be 1 to 65535");
    end

    //--------------------------------------------------------------
    // Functions
    //--------------------------------------------------------------
    function automatic logic [7:0] reset_value(input logic [4:0] idx);
        case (idx)
            tpg_pkg::IDX_CONTROL: reset_value = tpg_pkg::RST_CONTROL;
            tpg_pkg::IDX_CONFIG: reset_value = tpg_pkg::RST_CONFIG;
            tpg_pkg::IDX_LINE_SIZE_UPPER: reset_value = tpg_pkg::RST_LINE_SIZE_UPPER;
            tpg_pkg::IDX_LINE_SIZE_LOWER: reset_value = tpg_pkg::RST_LINE_SIZE_LOWER;
            tpg_pkg::IDX_BAR_SIZE_UPPER: reset_value = tpg_pkg::RST_BAR_SIZE_UPPER;
            tpg_pkg::IDX_BAR_SIZE_LOWER: reset_value = tpg_pkg::RST_BAR_SIZE_LOWER;
            tpg_pkg::IDX_ACTIVE_LINES_UPPER: reset_value = tpg_pkg::RST_ACTIVE_LINES_UPPER;
            tpg_pkg::IDX_ACTIVE_LINES_LOWER: reset_value = tpg_pkg::RST_ACTIVE_LINES_LOWER;
            tpg_pkg::IDX_TOTAL_LINES_UPPER: reset_value = tpg_pkg::RST_TOTAL_LINES_UPPER;
            tpg_pkg::IDX_TOTAL_LINES_LOWER: reset_value = tpg_pkg::RST_TOTAL_LINES_LOWER;
            tpg_pkg::IDX_LINE_PERIOD_UPPER: reset_value = tpg_pkg::RST_LINE_PERIOD_UPPER;
            tpg_pkg::IDX_LINE_PERIOD_LOWER: reset_value = tpg_pkg::RST_LINE_PERIOD_LOWER;
            tpg_pkg::IDX_BACK_PORCH_LINES: reset_value = tpg_pkg::RST_BACK_PORCH_LINES;
            tpg_pkg::IDX_FRONT_PORCH_LINES: reset_value = tpg_pkg::RST_FRONT_PORCH_LINES;
            tpg_pkg::IDX_PATTERN_BYTE_ZERO: reset_value = tpg_pkg::RST_PATTERN_BYTE_ZERO;
            tpg_pkg::IDX_PATTERN_BYTE_ONE: reset_value = tpg_pkg::RST_PATTERN_BYTE_ONE;
            tpg_pkg::IDX_PATTERN_BYTE_TWO: reset_value = tpg_pkg::RST_PATTERN_BYTE_TWO;
            default: reset_value = tpg_pkg::RST_ZERO;
        endcase
    endfunction : reset_value

    function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
        logic [4:0] idx;
        idx = addr[6:2];
        is_mapped = (addr[ADDR_W-1:7] == '0) &&
            (idx == tpg_pkg::IDX_CONTROL || idx == tpg_pkg::IDX_CONFIG || idx == tpg_pkg::IDX_STATUS ||
            (idx >= tpg_pkg::IDX_LINE_SIZE_UPPER && idx <= tpg_pkg::IDX_PATTERN_BYTE_TWO));
    endfunction : is_mapped

    function automatic logic [15:0] at_least_one(input logic [15:0] value);
        at_least_one = (value == 16'h0000) ? 16'h0001 : value;
    endfunction : at_least_one

    //--------------------------------------------------------------
    // Register file state
    //--------------------------------------------------------------
    logic [7:0] reg_q [0:tpg_pkg::REG_COUNT-1];
    logic awready_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic arready_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic run_q;
    logic active_q;
    logic [7:0] status_byte;
    logic wr_fire;
    logic rd_fire;

    assign wr_fire = awready_q && i_awvalid && i_wvalid;
    assign rd_fire = arready_q && i_arvalid;
    assign status_byte = {6'h00, active_q, run_q};

    //--------------------------------------------------------------
    // AXI4-Lite write channel
    //--------------------------------------------------------------
    always_ff @(posedge i_mclk)
    begin
        if (!i_resetn)
        begin
            awready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= tpg_pkg::RESP_OKAY;
        end
        else
        begin
            awready_q <= i_awvalid && i_wvalid && !bvalid_q && !awready_q;
            if (wr_fire)
            begin
                bvalid_q <= 1'b1;
                bresp_q <= is_mapped(i_awaddr) ? tpg_pkg::RESP_OKAY : tpg_pkg::RESP_SLVERR;
            end
            else if (i_bready)
                bvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_resetn)
        begin
            for (int i = 0; i < tpg_pkg::REG_COUNT; i++)
            begin
                reg_q[i] <= reset_value(5'(i));
            end
        end
        else if (wr_fire && i_wstrb[0] && is_mapped(i_awaddr))
        begin
            case (i_awaddr[6:2])
                tpg_pkg::IDX_STATUS: reg_q[tpg_pkg::IDX_STATUS] <= tpg_pkg::RST_ZERO;
                tpg_pkg::IDX_CONFIG: reg_q[tpg_pkg::IDX_CONFIG] <= i_wdata[7:0] & tpg_pkg::CFG_WRITE_MASK;
                tpg_pkg::IDX_CONTROL: reg_q[tpg_pkg::IDX_CONTROL] <= i_wdata[7:0] & tpg_pkg::CTRL_WRITE_MASK;
                default: reg_q[i_awaddr[6:2]] <= i_wdata[7:0];
            endcase
        end
    end

    //--------------------------------------------------------------
    // AXI4-Lite read channel
    //--------------------------------------------------------------
    always_ff @(posedge i_mclk)
    begin
        if (!i_resetn)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= tpg_pkg::RESP_OKAY;
            rdata_q <= 32'h00000000;
        end
        else
        begin
            arready_q <= i_arvalid && !rvalid_q && !arready_q;
            if (rd_fire)
            begin
                rvalid_q <= 1'b1;
                rresp_q <= is_mapped(i_araddr) ? tpg_pkg::RESP_OKAY : tpg_pkg::RESP_SLVERR;
                rdata_q <= !is_mapped(i_araddr) ? 32'h00000000 :
                    (i_araddr[6:2] == tpg_pkg::IDX_STATUS) ? {24'h000000, status_byte} :
                    {24'h000000, reg_q[i_araddr[6:2]]};
            end
            else if (i_rready)
                rvalid_q <= 1'b0;
        end
    end

    assign o_awready = awready_q;
    assign o_wready = awready_q;
    assign o_bvalid = bvalid_q;
    assign o_bresp = bresp_q;
    assign o_arready = arready_q;
    assign o_rvalid = rvalid_q;
    assign o_rresp = rresp_q;
    assign o_rdata = rdata_q;

    //--------------------------------------------------------------
    // Programmed values
    //--------------------------------------------------------------
    logic enable;
    logic fixed_mode;
    logic [2:0] last_bar;
    logic [3:0] block_len;
    logic [15:0] line_size;
    logic [15:0] bar_size;
    logic [15:0] active_lines;
    logic [15:0] total_lines;
    logic [15:0] line_period;
    logic [7:0] back_porch;
    logic [7:0] front_porch;
    logic [3:0] block_raw;

    assign enable = reg_q[tpg_pkg::IDX_CONTROL][tpg_pkg::CTRL_ENABLE_BIT];
    assign fixed_mode = reg_q[tpg_pkg::IDX_CONFIG][tpg_pkg::CFG_FIXED_BIT];
    assign last_bar = 3'((4'h1 << reg_q[tpg_pkg::IDX_CONFIG][tpg_pkg::CFG_BARS_LSB +: 2]) - 4'h1);
    assign block_raw = reg_q[tpg_pkg::IDX_CONFIG][tpg_pkg::CFG_BLOCK_LSB +: 4];
    assign block_len = (block_raw < tpg_pkg::BLOCK_MIN) ? tpg_pkg::BLOCK_MIN :
        (block_raw > tpg_pkg::BLOCK_MAX) ? tpg_pkg::BLOCK_MAX : block_raw;
    assign line_size = {reg_q[tpg_pkg::IDX_LINE_SIZE_UPPER], reg_q[tpg_pkg::IDX_LINE_SIZE_LOWER]};
    assign bar_size = at_least_one({reg_q[tpg_pkg::IDX_BAR_SIZE_UPPER], reg_q[tpg_pkg::IDX_BAR_SIZE_LOWER]});
    assign active_lines = {reg_q[tpg_pkg::IDX_ACTIVE_LINES_UPPER], reg_q[tpg_pkg::IDX_ACTIVE_LINES_LOWER]};
    assign total_lines = at_least_one({reg_q[tpg_pkg::IDX_TOTAL_LINES_UPPER],
        reg_q[tpg_pkg::IDX_TOTAL_LINES_LOWER]});
    assign line_period = at_least_one({reg_q[tpg_pkg::IDX_LINE_PERIOD_UPPER],
        reg_q[tpg_pkg::IDX_LINE_PERIOD_LOWER]});
    assign back_porch = reg_q[tpg_pkg::IDX_BACK_PORCH_LINES];
    assign front_porch = reg_q[tpg_pkg::IDX_FRONT_PORCH_LINES];

    //--------------------------------------------------------------
    // Line period timing in link units
    //--------------------------------------------------------------
    logic [15:0] unit_cnt_q;
    logic unit_tick;
    logic [15:0] period_cnt_q;
    logic line_end;
    logic [15:0] line_q;
    logic start_evt;
    logic [15:0] new_line;
    logic [17:0] active_end;
    logic [17:0] end_line;
    logic [17:0] fe_line;

    assign unit_tick = run_q && (unit_cnt_q == 16'(UNIT_CYCLES - 1));
    assign line_end = unit_tick && (period_cnt_q >= line_period - 16'h0001);
    assign start_evt = (enable && !run_q) || line_end;
    assign new_line = (!run_q || line_q >= total_lines - 16'h0001) ? 16'h0000 : line_q + 16'h0001;
    assign active_end = 18'(back_porch) + 18'(active_lines);
    assign end_line = active_end + 18'(front_porch);
    assign fe_line = (end_line < 18'(total_lines)) ? end_line : 18'(total_lines - 16'h0001);

    always_ff @(posedge i_mclk)
    begin
        if (!i_resetn || !enable)
        begin
            unit_cnt_q <= 16'h0000;
            period_cnt_q <= 16'h0000;
            line_q <= 16'h0000;
            run_q <= 1'b0;
        end
        else
        begin
            run_q <= 1'b1;
            unit_cnt_q <= (!run_q || unit_tick) ? 16'h0000 : unit_cnt_q + 16'h0001;
            if (start_evt)
            begin
                period_cnt_q <= 16'h0000;
                line_q <= new_line;
            end
            else if (unit_tick)
            begin
                period_cnt_q <= period_cnt_q + 16'h0001;
            end
        end
    end

    //--------------------------------------------------------------
    // Byte generation within active lines
    //--------------------------------------------------------------
    logic [15:0] bytes_left_q;
    logic [2:0] bar_idx_q;
    logic [15:0] bar_pos_q;
    logic [3:0] blk_idx_q;
    logic new_active;
    logic [3:0] byte_sel;
    logic [7:0] byte_value;

    assign new_active = (18'(new_line) >= 18'(back_porch)) && (18'(new_line) < active_end);
    assign byte_sel = fixed_mode ? blk_idx_q : {1'b0, bar_idx_q};

    always_comb
    begin
        case (byte_sel)
            4'h0: byte_value = reg_q[tpg_pkg::IDX_PATTERN_BYTE_ZERO];
            4'h1: byte_value = reg_q[tpg_pkg::IDX_PATTERN_BYTE_ONE];
            4'h2: byte_value = reg_q[tpg_pkg::IDX_PATTERN_BYTE_TWO];
            default: byte_value = tpg_pkg::UNPROGRAMMED_BYTE;
        endcase
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_resetn || !enable)
        begin
            bytes_left_q <= 16'h0000;
            bar_idx_q <= 3'h0;
            bar_pos_q <= 16'h0000;
            blk_idx_q <= 4'h0;
            active_q <= 1'b0;
        end
        else if (start_evt)
        begin
            bytes_left_q <= new_active ? line_size : 16'h0000;
            active_q <= new_active;
            bar_idx_q <= 3'h0;
            bar_pos_q <= 16'h0000;
            blk_idx_q <= 4'h0;
        end
        else if (bytes_left_q != 16'h0000)
        begin
            bytes_left_q <= bytes_left_q - 16'h0001;
            blk_idx_q <= (blk_idx_q >= block_len - 4'h1) ? 4'h0 : blk_idx_q + 4'h1;
            if (bar_idx_q < last_bar && bar_pos_q >= bar_size - 16'h0001)
            begin
                bar_idx_q <= bar_idx_q + 3'h1;
                bar_pos_q <= 16'h0000;
            end
            else
            begin
                bar_pos_q <= bar_pos_q + 16'h0001;
            end
        end
    end

    //--------------------------------------------------------------
    // Stream output
    //--------------------------------------------------------------
    always_ff @(posedge i_mclk)
    begin
        if (!i_resetn)
        begin
            o_stream <= '0;
        end
        else
        begin
            o_stream.frame_start <= start_evt && enable && new_line == 16'h0000;
            o_stream.frame_end <= start_evt && enable && 18'(new_line) == fe_line;
            o_stream.line_start <= start_evt && enable;
            o_stream.valid <= enable && !start_evt && bytes_left_q != 16'h0000;
            o_stream.last <= enable && !start_evt && bytes_left_q == 16'h0001;
            o_stream.data <= (enable && !start_evt && bytes_left_q != 16'h0000) ? byte_value : 8'h00;
        end
    end

endmodule : tpg_frame_timing

// ==== tb/tpg_frame_timing_chk.sv ====
// Port checker of the test pattern frame timer
`timescale 1ns/1ns
module tpg_frame_timing_chk
(
    input wire logic i_mclk,
    input wire logic i_resetn,
    input wire logic i_bready,
    input wire logic i_rready,
    input wire logic o_awready,
    input wire logic [1:0] o_bresp,
    input wire logic o_bvalid,
    input wire logic o_arready,
    input wire logic [31:0] o_rdata,
    input wire logic o_rvalid,
    input wire tpg_pkg::tpg_stream_type o_stream
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);
    // ----------------
    // Bus and stream
    // ----------------
    b_follow_a: assert property (o_awready |=> o_bvalid)
        else $error("write answer late");
    b_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write answer dropped");
    r_follow_a: assert property (o_arready |=> o_rvalid)
        else $error("read answer late");
    r_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read answer dropped");
    last_valid_a: assert property (o_stream.last |-> o_stream.valid)
        else $error("last without byte");
    idle_data_a: assert property (!o_stream.valid |-> o_stream.data == 8'h00)
        else $error("data outside bytes");
    frame_line_a: assert property (o_stream.frame_start |-> o_stream.line_start)
        else $error("frame start off line start");
    valid_start_a: assert property ($rose(o_stream.valid) |-> $past(o_stream.line_start))
        else $error("bytes not after line start");
    last_gap_a: assert property (o_stream.last |=> !o_stream.valid)
        else $error("bytes run past last");
endmodule : tpg_frame_timing_chk

bind tpg_frame_timing tpg_frame_timing_chk u_tpg_frame_timing_chk (.i_mclk, .i_resetn, .i_bready,
    .i_rready, .o_awready, .o_bresp, .o_bvalid, .o_arready, .o_rdata, .o_rvalid, .o_stream);

// ==== tb/tpg_stream_sink.sv ====
// Downstream packet path model that measures the generated frames
`timescale 1ns/1ns
module tpg_stream_sink
(
    input wire logic i_mclk,
    input wire tpg_pkg::tpg_stream_type i_stream,
    output logic [15:0] o_frame_lines,
    output logic [15:0] o_period,
    output logic [15:0] o_first_act,
    output logic [15:0] o_last_act,
    output logic [15:0] o_end_line,
    output logic [15:0] o_line_bytes,
    output logic [7:0] o_bytes [8]
);
    logic [15:0] line_q;
    logic [15:0] cyc_q;
    logic [15:0] cnt_q;
    logic seen_q;
    // Line count latches at each frame start, period at each line start; first frame is junk
    always_ff @(posedge i_mclk)
    begin
        cyc_q <= i_stream.line_start ? 16'h0001 : cyc_q + 16'h0001;
        if (i_stream.line_start)
        begin
            o_period <= cyc_q;
            cnt_q <= 16'h0000;
            line_q <= i_stream.frame_start ? 16'h0000 : line_q + 16'h0001;
        end
        if (i_stream.frame_start)
        begin
            o_frame_lines <= line_q + 16'h0001;
            seen_q <= 1'b0;
        end
        if (i_stream.frame_end)
            o_end_line <= i_stream.line_start ? line_q + 16'h0001 : line_q;
        if (i_stream.valid)
        begin
            o_bytes[cnt_q[2:0]] <= i_stream.data;
            cnt_q <= cnt_q + 16'h0001;
            o_last_act <= line_q;
            seen_q <= 1'b1;
            if (!seen_q)
                o_first_act <= line_q;
            if (i_stream.last)
                o_line_bytes <= cnt_q + 16'h0001;
        end
    end
endmodule : tpg_stream_sink

// ==== tb/test_tpg_frame_timing.sv ====
// Self-checking bench of the test pattern frame timer
`timescale 1ns/1ns
module test_tpg_frame_timing;
    // Index in upper byte, value in lower; enable comes last
    localparam logic [15:0] PROG [17] = '{16'h0A00, 16'h0B0C, 16'h0C00, 16'h0D14, 16'h0400, 16'h0508,
        16'h0600, 16'h0702, 16'h0800, 16'h0903, 16'h0E02, 16'h0F02, 16'h105A, 16'h11C3, 16'h1296,
        16'h0223, 16'h0101};
    localparam logic [71:0] RST_TABLE = 72'h020D0C67210AAA33F0;
    localparam logic [71:0] PATTERNS [6] = '{72'h035A5A5A5A5A5A5A5A, 72'h135A5AC3C3C3C3C3C3,
        72'h235A5AC3C396960000, 72'h335A5AC3C396960000, 72'h855AC39600005AC396, 72'h8C5AC3960000000000};
    logic i_mclk = 1'b0;
    logic i_resetn = 1'b0;
    logic [7:0] i_awaddr = 8'h00;
    logic [7:0] i_araddr = 8'h00;
    logic [31:0] i_wdata = 32'h00000000;
    logic [3:0] i_wstrb = 4'hF;
    logic i_awvalid = 1'b0;
    logic i_wvalid = 1'b0;
    logic i_bready = 1'b0;
    logic i_arvalid = 1'b0;
    logic i_rready = 1'b0;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [1:0] o_bresp, o_rresp, resp;
    logic [31:0] o_rdata, rd;
    tpg_pkg::tpg_stream_type o_stream;
    logic [15:0] lines, period, first_act, last_act, end_line, line_bytes;
    logic [7:0] bytes [8];
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;

    always #25 i_mclk = ~i_mclk;

    tpg_frame_timing #(.ADDR_W(8), .UNIT_CYCLES(1)) u_tpg_frame_timing (.i_mclk, .i_resetn, .i_awaddr,
        .i_awvalid, .o_awready, .i_wdata, .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
        .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .o_stream);
    tpg_stream_sink u_tpg_stream_sink (.i_mclk, .i_stream(o_stream), .o_frame_lines(lines),
        .o_period(period), .o_first_act(first_act), .o_last_act(last_act), .o_end_line(end_line),
        .o_line_bytes(line_bytes), .o_bytes(bytes));

    task automatic end_of_test();
        if (mismatches == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test

    task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
        tests_run++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t ns: %s", $time, what);
        end
    endtask : check

    task automatic axi_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        i_awaddr <= a;
        i_wdata <= {24'h000000, d};
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        do @(posedge i_mclk); while (o_awready !== 1'b1);
        check(o_wready, 1'b1, "write data ready");
        i_awvalid <= 1'b0;
        i_wvalid <= 1'b0;
        do @(posedge i_mclk); while (o_bvalid !== 1'b1);
        resp = o_bresp;
        i_bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [7:0] a);
        @(posedge i_mclk);
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        do @(posedge i_mclk); while (o_arready !== 1'b1);
        i_arvalid <= 1'b0;
        do @(posedge i_mclk); while (o_rvalid !== 1'b1);
        rd = o_rdata;
        resp = o_rresp;
        i_rready <= 1'b0;
    endtask : axi_read

    task automatic wait_frame();
        do @(posedge i_mclk); while (o_stream.frame_start !== 1'b1);
        @(negedge i_mclk);
    endtask : wait_frame

    task automatic check_reset_values();
        for (int i = 0; i < 9; i++)
        begin
            axi_read({1'b0, 5'h0A + i[4:0], 2'b00});
            check(rd, {24'h000000, RST_TABLE[71-8*i -: 8]}, "reset value");
            check(resp, 2'h0, "read response");
        end
    endtask : check_reset_values

    task automatic check_unmapped();
        axi_write(8'h78, 8'h55);
        check(resp, 2'h2, "unmapped write response");
        axi_read(8'h78);
        check({rd, 30'h0, resp}, 64'h2, "unmapped read");
    endtask : check_unmapped

    task automatic check_frame_timing();
        for (int i = 0; i < 17; i++)
            axi_write({1'b0, PROG[i][12:8], 2'b00}, PROG[i][7:0]);
        axi_read(8'h2C);
        check(rd, 32'h0C, "total lines readback");
        wait_frame();
        wait_frame();
        check(lines, 16'h000C, "lines per frame");
        check(period, 16'h0014, "line period");
        check(first_act, 16'h0002, "first active line");
        check(last_act, 16'h0004, "last active line");
        check(end_line, 16'h0007, "frame end line");
        check(line_bytes, 16'h0008, "bytes per line");
    endtask : check_frame_timing

    task automatic check_reset_mid_run();
        axi_read(8'h7C);
        check(rd[0], 1'b1, "running status");
        @(posedge i_mclk);
        i_resetn <= 1'b0;
        repeat (2) @(posedge i_mclk);
        i_resetn <= 1'b1;
        @(negedge i_mclk);
        check(o_stream, 64'h0, "stream after reset");
        axi_read(8'h2C);
        check(rd, 32'h0000000D, "total lines after reset");
        axi_read(8'h7C);
        check(rd, 32'h00000000, "stopped status");
    endtask : check_reset_mid_run

    task automatic check_patterns();
        for (int i = 0; i < 6; i++)
        begin
            axi_write(8'h08, PATTERNS[i][71:64]);
            wait_frame();
            wait_frame();
            check({bytes[0], bytes[1], bytes[2], bytes[3], bytes[4], bytes[5], bytes[6], bytes[7]},
                PATTERNS[i][63:0], "pattern bytes");
        end
    endtask : check_patterns

    always @(posedge i_mclk)
    begin
        cycles++;
        if (cycles > 20000)
        begin
            mismatches++;
            end_of_test();
        end
    end

    initial
    begin
        repeat (10) @(posedge i_mclk);
        i_resetn <= 1'b1;
        check_reset_values();
        check_unmapped();
        check_frame_timing();
        check_patterns();
        check_reset_mid_run();
        end_of_test();
    end
endmodule : test_tpg_frame_timing
